// [logic/eic_edge_det.sv]
// module: two-flop synchronisers and edge detectors for the asynchronous interrupt pins
`timescale 1ns/1ps
module eic_edge_det #(
    parameter int N = 4
) (
    input  wire logic         sys_clk, // processor clock
    input  wire logic         rst,     // async reset, active high
    input  wire logic [N-1:0] pins,    // raw pin levels
    eic_pins_if.det           edges    // edge strobes out
);
    import eic_pkg::*;

    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;
    logic [N-1:0] next_sync1;
    logic [N-1:0] next_sync2;
    logic [N-1:0] next_prev;

    // elaboration check: the interface carries four rise and four fall strobes
    generate
        if (N != EIC_NUM_PINS) begin : g_bad_n
            $error("eic_edge_det: pin count must match interface");
        end
    endgenerate

    // sync1 feeds only sync2; edges are taken between sync2 and prev
    always_comb begin
        next_sync1 = pins;
        next_sync2 = sync1;
        next_prev  = sync2;
    end

    // pins idle low after reset so a pin already high yields one rise; accepted
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
            prev  <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            prev  <= next_prev;
        end
    end

    // a rise and a fall strobe per bit
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_edge
            assign edges.rise[g] = sync2[g] & ~prev[g];
            assign edges.fall[g] = ~sync2[g] & prev[g];
        end
    endgenerate

    // strobes must trail the raw pin by exactly the two sync stages
    a_rise_one_cycle: assert property (@(posedge sys_clk) disable iff (rst)
        edges.rise[0] |=> !edges.rise[0]) else $error("rise strobe longer than a cycle");
    a_rise_follows_pin: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(pins[0]) |-> ##2 edges.rise[0]) else $error("wake rise strobe missing");
    a_fall_follows_pin: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(pins[2]) |-> ##2 edges.fall[2]) else $error("ext5 fall strobe missing");
endmodule // eic_edge_det

// [logic/eic_pins_if.sv]
// interface: rise and fall edge strobes between edge detector and core logic
`timescale 1ns/1ps
interface eic_pins_if;
    logic [3:0] rise; // one-cycle rising-edge strobes: ext6, ext5, ext4, wake
    logic [3:0] fall; // one-cycle falling-edge strobes
    modport det (output rise, output fall);
    modport use_ (input rise, input fall);
endinterface

// [logic/eic_pkg.sv]
// package: register offsets, bit positions, reset values and synchronised pin count for the extended irq block
package eic_pkg;
    // special-function register offsets on the core's internal bus
    localparam logic [7:0] EIC_FLAGS_ADDR = 8'h91;
    localparam logic [7:0] EIC_CTRL_ADDR  = 8'hd8;
    localparam logic [7:0] EIC_EN_ADDR    = 8'he8;
    localparam logic [7:0] EIC_PRI_ADDR   = 8'hf8;
    // flag register bit positions
    localparam int EIC_F_EXT5 = 7;
    localparam int EIC_F_EXT4 = 6;
    localparam int EIC_F_TWI  = 5;
    localparam int EIC_F_USB  = 4;
    // control register bit positions
    localparam int EIC_C_DBL  = 7;
    localparam int EIC_C_RENA = 5;
    localparam int EIC_C_RES  = 4;
    localparam int EIC_C_EXT6 = 3;
    // enable and priority bit positions (same layout in both)
    localparam int EIC_S_EXT6 = 4;
    localparam int EIC_S_EXT5 = 3;
    localparam int EIC_S_EXT4 = 2;
    localparam int EIC_S_TWI  = 1;
    localparam int EIC_S_USB  = 0;
    // fixed read values of reserved bits and masks of live bits
    localparam logic [7:0] EIC_FLAGS_FIXED = 8'h08;
    localparam logic [7:0] EIC_FLAGS_LIVE  = 8'hf0;
    localparam logic [7:0] EIC_CTRL_FIXED  = 8'h40;
    localparam logic [7:0] EIC_CTRL_LIVE   = 8'hb8;
    localparam logic [7:0] EIC_SRC_FIXED   = 8'he0;
    localparam logic [7:0] EIC_SRC_LIVE    = 8'h1f;
    // reset values of the live bits
    localparam logic [7:0] EIC_RST_VAL     = 8'h00;
    // number of pins sampled through the synchroniser
    localparam int EIC_NUM_PINS = 4;
endpackage

// [logic/eic_top.sv]
// module: extended interrupt flags, enables and priorities behind four special-function registers
// Operation
// - ext5 pin falling edge sets its flag
// - ext4 pin rising edge sets its flag
// - two-wire controller request sets its flag
// - usb interface request sets its flag
// - flags sticky; only software zero clears
// - software writing one raises enabled request
// - reserved bits read fixed ones or zeros
// - doubler bit doubles serial port 1 rate
// - resume enable gates the resume request
// - wake rise or usb resume sets flag
// - resume flag left set reasserts request
// - ext6 pin rising edge sets its flag
// - enable register holds one bit per source except resume
// - priority register selects high or low
// - sources occupy remapped slots, no clock
// - global gate masks all except resume
`timescale 1ns/1ps
module eic_top (
    input  wire logic       sys_clk,            // processor clock, 25 MHz
    input  wire logic       rst,                // async reset, active high
    input  wire logic [7:0] sfr_addr,           // special-function register address
    input  wire logic       sfr_wr,             // write strobe, one cycle
    input  wire logic [7:0] sfr_wdata,          // write data
    input  wire logic       sfr_rd,             // read strobe, one cycle
    output logic      [7:0] sfr_rdata,          // read data, registered
    output logic            sfr_hit,            // address maps to this block, registered
    input  wire logic       global_irq_gate,    // global enable bit from the core
    input  wire logic       ext4_pin,           // external-4 pin, active rising
    input  wire logic       ext5_pin,           // external-5 pin, active falling
    input  wire logic       ext6_pin,           // external-6 pin, active rising
    input  wire logic       wake_pin,           // wakeup pin, active rising
    input  wire logic       usb_irq_req,        // usb interface request pulse, same clock
    input  wire logic       two_wire_irq_req,   // two-wire controller request pulse, same clock
    input  wire logic       usb_resume_evt,     // usb resumed from suspend pulse, same clock
    output logic            uart1_baud_doubler, // serial port 1 runs double rate
    output logic            resume_irq_req,     // resume request, highest level
    output logic            usb_irq_req_out,    // request in the external-2 slot
    output logic            two_wire_irq_out,   // request in the external-3 slot
    output logic            ext4_irq_req,       // external-4 request
    output logic            ext5_irq_req,       // external-5 request
    output logic            ext6_irq_req,       // request in the watchdog slot
    output logic      [4:0] src_high_pri        // per source high priority, enable layout
);
    import eic_pkg::*;

    eic_pins_if pins_bus ();

    // pins: ext6=3, ext5=2, ext4=1, wake=0
    eic_edge_det #(
        .N(EIC_NUM_PINS)
    ) u_edge (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pins    ({ext6_pin, ext5_pin, ext4_pin, wake_pin}),
        .edges   (pins_bus.det)
    );

    logic       ext5_edge_flag;
    logic       ext4_edge_flag;
    logic       two_wire_irq_flag;
    logic       usb_irq_flag;
    logic       resume_flag;
    logic       ext6_flag;
    logic       resume_irq_enable;
    logic [4:0] ext_irq_enables;
    logic [4:0] ext_irq_priorities;
    logic       next_uart1_baud_doubler;
    logic       next_ext5_edge_flag;
    logic       next_ext4_edge_flag;
    logic       next_two_wire_irq_flag;
    logic       next_usb_irq_flag;
    logic       next_resume_flag;
    logic       next_ext6_flag;
    logic       next_resume_irq_enable;
    logic [4:0] next_ext_irq_enables;
    logic [4:0] next_ext_irq_priorities;
    logic [7:0] next_sfr_rdata;
    logic       next_sfr_hit;
    logic       wr_flags;
    logic       wr_ctrl;
    logic       wr_en;
    logic       wr_pri;
    logic       set_ext5;
    logic       set_ext4;
    logic       set_ext6;
    logic       set_res;

    // hardware set events
    assign set_ext5 = pins_bus.fall[2];
    assign set_ext4 = pins_bus.rise[1];
    assign set_ext6 = pins_bus.rise[3];
    assign set_res  = pins_bus.rise[0] | usb_resume_evt;

    // write decode
    assign wr_flags = sfr_wr && (sfr_addr == EIC_FLAGS_ADDR);
    assign wr_ctrl  = sfr_wr && (sfr_addr == EIC_CTRL_ADDR);
    assign wr_en    = sfr_wr && (sfr_addr == EIC_EN_ADDR);
    assign wr_pri   = sfr_wr && (sfr_addr == EIC_PRI_ADDR);

    // flag next values: software write stores the bit, hardware set then ORs on top so it wins
    always_comb begin
        next_ext5_edge_flag    = ext5_edge_flag;
        next_ext4_edge_flag    = ext4_edge_flag;
        next_two_wire_irq_flag = two_wire_irq_flag;
        next_usb_irq_flag      = usb_irq_flag;
        next_resume_flag       = resume_flag;
        next_ext6_flag         = ext6_flag;
        if (wr_flags) begin
            // a written one sets the flag just like an event
            next_ext5_edge_flag    = sfr_wdata[EIC_F_EXT5];
            next_ext4_edge_flag    = sfr_wdata[EIC_F_EXT4];
            next_two_wire_irq_flag = sfr_wdata[EIC_F_TWI];
            next_usb_irq_flag      = sfr_wdata[EIC_F_USB];
        end
        if (wr_ctrl) begin
            next_resume_flag = sfr_wdata[EIC_C_RES];
            next_ext6_flag   = sfr_wdata[EIC_C_EXT6];
        end
        next_ext5_edge_flag    = next_ext5_edge_flag | set_ext5;
        next_ext4_edge_flag    = next_ext4_edge_flag | set_ext4;
        next_two_wire_irq_flag = next_two_wire_irq_flag | two_wire_irq_req;
        next_usb_irq_flag      = next_usb_irq_flag | usb_irq_req;
        next_resume_flag       = next_resume_flag | set_res;
        next_ext6_flag         = next_ext6_flag | set_ext6;
    end

    // control, enable and priority next values
    always_comb begin
        next_uart1_baud_doubler = uart1_baud_doubler;
        next_resume_irq_enable  = resume_irq_enable;
        next_ext_irq_enables    = ext_irq_enables;
        next_ext_irq_priorities = ext_irq_priorities;
        if (wr_ctrl) begin
            next_uart1_baud_doubler = sfr_wdata[EIC_C_DBL];
            next_resume_irq_enable  = sfr_wdata[EIC_C_RENA];
        end
        if (wr_en) begin
            next_ext_irq_enables = sfr_wdata[4:0];
        end
        if (wr_pri) begin
            next_ext_irq_priorities = sfr_wdata[4:0];
        end
    end

    // read mux: reserved bits forced to fixed values, unmapped address reads zero
    always_comb begin
        next_sfr_rdata = sfr_rdata;
        next_sfr_hit   = 1'b0;
        if (sfr_rd) begin
            next_sfr_hit = 1'b1;
            unique case (sfr_addr)
                EIC_FLAGS_ADDR: next_sfr_rdata = EIC_FLAGS_FIXED | (EIC_FLAGS_LIVE &
                    {ext5_edge_flag, ext4_edge_flag, two_wire_irq_flag, usb_irq_flag,
                     4'h0});
                EIC_CTRL_ADDR:  next_sfr_rdata = EIC_CTRL_FIXED | (EIC_CTRL_LIVE &
                    {uart1_baud_doubler, 1'b0, resume_irq_enable, resume_flag,
                     ext6_flag, 3'h0});
                EIC_EN_ADDR:    next_sfr_rdata = EIC_SRC_FIXED | {3'h0, ext_irq_enables};
                EIC_PRI_ADDR:   next_sfr_rdata = EIC_SRC_FIXED | {3'h0, ext_irq_priorities};
                default: begin
                    next_sfr_rdata = 8'h00;
                    next_sfr_hit   = 1'b0;
                end
            endcase
        end
    end

    // all state registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext5_edge_flag     <= 1'b0;
            ext4_edge_flag     <= 1'b0;
            two_wire_irq_flag  <= 1'b0;
            usb_irq_flag       <= 1'b0;
            resume_flag        <= 1'b0;
            ext6_flag          <= 1'b0;
            uart1_baud_doubler <= 1'b0;
            resume_irq_enable  <= 1'b0;
            ext_irq_enables    <= EIC_RST_VAL[4:0];
            ext_irq_priorities <= EIC_RST_VAL[4:0];
            sfr_rdata          <= EIC_RST_VAL;
            sfr_hit            <= 1'b0;
        end else begin
            ext5_edge_flag     <= next_ext5_edge_flag;
            ext4_edge_flag     <= next_ext4_edge_flag;
            two_wire_irq_flag  <= next_two_wire_irq_flag;
            usb_irq_flag       <= next_usb_irq_flag;
            resume_flag        <= next_resume_flag;
            ext6_flag          <= next_ext6_flag;
            uart1_baud_doubler <= next_uart1_baud_doubler;
            resume_irq_enable  <= next_resume_irq_enable;
            ext_irq_enables    <= next_ext_irq_enables;
            ext_irq_priorities <= next_ext_irq_priorities;
            sfr_rdata          <= next_sfr_rdata;
            sfr_hit            <= next_sfr_hit;
        end
    end

    // requests are levels from the sticky flags, so an uncleared flag re-requests at once
    assign resume_irq_req   = resume_flag & resume_irq_enable;
    assign usb_irq_req_out  = global_irq_gate & usb_irq_flag &
                              ext_irq_enables[EIC_S_USB];
    assign two_wire_irq_out = global_irq_gate & two_wire_irq_flag &
                              ext_irq_enables[EIC_S_TWI];
    assign ext4_irq_req     = global_irq_gate & ext4_edge_flag &
                              ext_irq_enables[EIC_S_EXT4];
    assign ext5_irq_req     = global_irq_gate & ext5_edge_flag &
                              ext_irq_enables[EIC_S_EXT5];
    assign ext6_irq_req     = global_irq_gate & ext_irq_enables[EIC_S_EXT6] & ext6_flag;
    // the core ranks levels; resume is always highest and has no bit here
    assign src_high_pri     = ext_irq_priorities;

    // checks; pin paths allow two sync flops, the edge and the flag register
    a_ext5_fall_set: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(ext5_pin) |-> ##3 ext5_edge_flag) else $error("ext5 fall did not set flag");
    a_ext4_rise_set: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ext4_pin) |-> ##3 ext4_edge_flag) else $error("ext4 rise did not set flag");
    a_twi_req_set: assert property (@(posedge sys_clk) disable iff (rst)
        two_wire_irq_req |=> two_wire_irq_flag) else $error("two-wire flag not set");
    a_usb_req_set: assert property (@(posedge sys_clk) disable iff (rst)
        usb_irq_req |=> usb_irq_flag) else $error("usb flag not set");
    a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        usb_irq_flag && !wr_flags |=> usb_irq_flag) else $error("usb flag dropped by itself");
    a_soft_set_req: assert property (@(posedge sys_clk) disable iff (rst)
        wr_flags && sfr_wdata[EIC_F_USB] && ext_irq_enables[EIC_S_USB] && !wr_en
        ##1 global_irq_gate |-> usb_irq_req_out) else $error("software set gave no request");
    a_flags_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
        $past(sfr_rd) && $past(sfr_addr) == EIC_FLAGS_ADDR |-> sfr_rdata[3:0] == 4'h8)
        else $error("flag reserved bits wrong");
    a_en_rsvd: assert property (@(posedge sys_clk) disable iff (rst)
        $past(sfr_rd) && $past(sfr_addr) == EIC_EN_ADDR |-> sfr_rdata[7:5] == 3'h7)
        else $error("enable reserved bits wrong");
    a_doubler_wr: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> uart1_baud_doubler == $past(sfr_wdata[EIC_C_DBL]))
        else $error("doubler not stored");
    a_resume_gate: assert property (@(posedge sys_clk) disable iff (rst)
        !resume_irq_enable |-> !resume_irq_req) else $error("resume not gated");
    a_wake_set: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(wake_pin) |-> ##3 resume_flag) else $error("wake rise did not set resume");
    a_ext6_set: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ext6_pin) |-> ##3 ext6_flag) else $error("ext6 rise did not set flag");
    a_gate_masks: assert property (@(posedge sys_clk) disable iff (rst)
        !global_irq_gate |-> !(usb_irq_req_out | two_wire_irq_out | ext4_irq_req |
        ext5_irq_req | ext6_irq_req)) else $error("global gate leaked");
    a_set_beats_clr: assert property (@(posedge sys_clk) disable iff (rst)
        wr_flags && !sfr_wdata[EIC_F_USB] && usb_irq_req |=> usb_irq_flag)
        else $error("clear beat hardware set");
endmodule // eic_top

// [verif/eic_src_model.sv]
// partner model: peripheral request pulses and interrupt pin levels seen by the block
`timescale 1ns/1ps
module eic_src_model (
    input  wire logic [2:0] cmd,        // one-cycle requests: resume evt, two-wire, usb
    input  wire logic [3:0] lvl,        // pin levels: wake, ext6, ext5, ext4
    output logic            usb_req,    // usb interface request pulse
    output logic            twi_req,    // two-wire controller request pulse
    output logic            resume_evt, // usb resumed from suspend
    output logic            ext4,       // external-4 pin
    output logic            ext5,       // external-5 pin, idles high
    output logic            ext6,       // external-6 pin
    output logic            wake        // wakeup pin
);
    // requests follow clock-aligned commands, so each lasts exactly one cycle
    assign usb_req    = cmd[0];
    assign twi_req    = cmd[1];
    assign resume_evt = cmd[2];
    // pins are plain levels; each state is held far longer than the sync depth needs
    assign ext4 = lvl[0];
    assign ext5 = lvl[1];
    assign ext6 = lvl[2];
    assign wake = lvl[3];
endmodule // eic_src_model

// [verif/ext_interrupt_control_tb.sv]
// testbench: register access, event sources and request outputs of the extended irq block
`timescale 1ns/1ps
module ext_interrupt_control_tb;
    import eic_pkg::*;
    logic       sys_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, gate = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, m_f, m_c, m_e, m_p;
    logic [2:0] cmd = 3'b000;
    logic [3:0] lvl = 4'b0010;
    logic [4:0] hpri;
    logic       hit, dbl, rreq, ureq, treq, r4, r5, r6, p_usb, p_twi, p_res, p4, p5, p6, pw;
    logic [7:0] addrs [5] = '{EIC_FLAGS_ADDR, EIC_CTRL_ADDR, EIC_EN_ADDR, EIC_PRI_ADDR, 8'h90};
    int         n_mismatch = 0, n_tests = 0, seed = 71905, r;

    eic_src_model u_src (.cmd(cmd), .lvl(lvl), .usb_req(p_usb), .twi_req(p_twi),
        .resume_evt(p_res), .ext4(p4), .ext5(p5), .ext6(p6), .wake(pw));
    eic_top u_dut (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(hit),
        .global_irq_gate(gate), .ext4_pin(p4), .ext5_pin(p5), .ext6_pin(p6), .wake_pin(pw),
        .usb_irq_req(p_usb), .two_wire_irq_req(p_twi), .usb_resume_evt(p_res),
        .uart1_baud_doubler(dbl), .resume_irq_req(rreq), .usb_irq_req_out(ureq),
        .two_wire_irq_out(treq), .ext4_irq_req(r4), .ext5_irq_req(r5), .ext6_irq_req(r6),
        .src_high_pri(hpri));

    // 25 MHz processor clock
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // expected read value: live bits from the model, reserved bits fixed
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            EIC_FLAGS_ADDR: exp_rd = (m_f & EIC_FLAGS_LIVE) | EIC_FLAGS_FIXED;
            EIC_CTRL_ADDR:  exp_rd = (m_c & EIC_CTRL_LIVE) | EIC_CTRL_FIXED;
            EIC_EN_ADDR:    exp_rd = (m_e & EIC_SRC_LIVE) | EIC_SRC_FIXED;
            EIC_PRI_ADDR:   exp_rd = (m_p & EIC_SRC_LIVE) | EIC_SRC_FIXED;
            default:        exp_rd = 8'h00;
        endcase
    endfunction

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one read strobe; data and hit land one cycle later
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1;
        chk("rdata", exp_rd(a), sfr_rdata);
        chk("hit", {7'h00, a != 8'h90}, {7'h00, hit});
    endtask

    // one write strobe; the model follows only mapped addresses
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        case (a)
            EIC_FLAGS_ADDR: m_f = d;
            EIC_CTRL_ADDR:  m_c = d;
            EIC_EN_ADDR:    m_e = d;
            EIC_PRI_ADDR:   m_p = d;
            default:        m_f = m_f;
        endcase
    endtask

    // request outputs against flags, enables and the global gate
    task automatic outs();
        logic [7:0] e;
        #1;
        e = {1'b0, m_c[7], m_c[4] & m_c[5], gate & m_e[0] & m_f[4], gate & m_e[1] & m_f[5],
            gate & m_e[2] & m_f[6], gate & m_e[3] & m_f[7], gate & m_e[4] & m_c[3]};
        chk("reqs", e, {1'b0, dbl, rreq, ureq, treq, r4, r5, r6});
        chk("hpri", {3'b000, m_p[4:0]}, {3'b000, hpri});
    endtask

    task automatic regs();
        for (int i = 0; i < 5; i++) rd(addrs[i]);
        outs();
    endtask

    // one hardware event: 0 usb, 1 two-wire, 2 usb resume, 3 ext4, 4 ext5, 5 ext6, 6 wake
    task automatic ev(input int k);
        @(posedge sys_clk);
        if (k < 3) cmd[k] <= 1'b1;
        else lvl[k-3] <= ~lvl[k-3];
        @(posedge sys_clk);
        cmd <= 3'b000;
        repeat (6) @(posedge sys_clk);
        if (k > 2) lvl[k-3] <= ~lvl[k-3];
        repeat (6) @(posedge sys_clk);
        case (k)
            0: m_f[4] = 1'b1;
            1: m_f[5] = 1'b1;
            3: m_f[6] = 1'b1;
            4: m_f[7] = 1'b1;
            5: m_c[3] = 1'b1;
            default: m_c[4] = 1'b1;
        endcase
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 20000 cycles
    initial begin
        #(40 * 20000);
        n_mismatch++;
        $display("BAD watchdog expected done seen hang");
        conclude();
    end

    // main sequence
    initial begin
        {m_f, m_c, m_e, m_p} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        regs();
        // random register traffic with the gate toggling
        for (int i = 0; i < 48; i++) begin
            r = $random(seed);
            @(posedge sys_clk);
            gate <= r[8];
            wr(addrs[r[2:0] % 5], r[23:16]);
            outs();
            if (i % 8 == 7) regs();
        end
        // resume request ignores the gate and stays while its flag is left set
        @(posedge sys_clk);
        gate <= 1'b0;
        wr(EIC_CTRL_ADDR, 8'h30);
        repeat (10) @(posedge sys_clk);
        outs();
        wr(EIC_CTRL_ADDR, 8'h00);
        outs();
        // every hardware source, all enabled, flags cleared first
        @(posedge sys_clk);
        gate <= 1'b1;
        wr(EIC_EN_ADDR, 8'hff);
        wr(EIC_FLAGS_ADDR, 8'h00);
        wr(EIC_CTRL_ADDR, 8'h20);
        for (int k = 0; k < 7; k++) begin
            if (k == 6) wr(EIC_CTRL_ADDR, 8'h20);
            ev(k);
            regs();
        end
        // flags stay until software writes zero
        repeat (30) @(posedge sys_clk);
        regs();
        wr(EIC_FLAGS_ADDR, 8'h00);
        regs();
        // hardware set meets a software clear in the same cycle
        @(posedge sys_clk);
        sfr_addr  <= EIC_FLAGS_ADDR;
        sfr_wdata <= 8'h00;
        sfr_wr    <= 1'b1;
        cmd[0]    <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        cmd    <= 3'b000;
        m_f    = 8'h10;
        regs();
        // second reset in mid-run clears every output
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk("rst outs", 8'h00, {1'b0, dbl, rreq, ureq, treq, r4, r5, r6});
        chk("rst rdata", 8'h00, sfr_rdata);
        {m_f, m_c, m_e, m_p} = '0;
        @(posedge sys_clk);
        rst <= 1'b0;
        regs();
        conclude();
    end
endmodule // ext_interrupt_control_tb
